// File: shared/txlen_pkg.sv
package txlen_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [4:0] TXLEN_ADDR_HIGH   = 5'h1D;
    localparam logic [4:0] TXLEN_ADDR_LOW    = 5'h1E;
    localparam logic [4:0] TXLEN_ADDR_FIFO   = 5'h1C;
    localparam logic [7:0] TXLEN_RESET_VALUE = 8'h00;

    // ------------------------------------------------------------------
    // Field positions of the second length register
    // ------------------------------------------------------------------
    localparam int TXLEN_LOW_NIB_MSB  = 7;
    localparam int TXLEN_LOW_NIB_LSB  = 4;
    localparam int TXLEN_PART_MSB     = 3;
    localparam int TXLEN_PART_LSB     = 1;
    localparam int TXLEN_PART_FLAG    = 0;

    // ------------------------------------------------------------------
    // FIFO status layout and depth
    // ------------------------------------------------------------------
    localparam int         TXLEN_FIFO_DEPTH = 12;
    localparam int         TXLEN_FSTAT_OVF  = 4;
    localparam logic [3:0] TXLEN_CNT_ZERO   = 4'h0;
    localparam logic [3:0] TXLEN_CNT_FULL   = 4'hC;

    // ------------------------------------------------------------------
    // Encoder states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TXLEN_IDLE  = 2'b00,
        TXLEN_BYTES = 2'b01,
        TXLEN_PART  = 2'b11,
        TXLEN_EOF   = 2'b10
    } txlen_state_t;

endpackage

// File: core/txlen_fifo_mem.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Small FIFO storage with registered read data
// ----------------------------------------------------------------------
module txlen_fifo_mem
    import txlen_pkg::*;
(
    // Clock
    input  wire logic       core_clk,
    // Write port
    input  wire logic       wrEn,
    input  wire logic [3:0] wrAddr,
    input  wire logic [7:0] wrData,
    // Read port
    input  wire logic [3:0] rdAddr,
    output logic      [7:0] rdData
);

    logic [7:0] mem [TXLEN_FIFO_DEPTH];

    // Storage and registered read
    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end

endmodule // txlen_fifo_mem

// File: core/txlen_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - The first length register holds byte count bits 11..4, bit 11 at bit 7.
// - The second length register holds byte count bits 3..0 in bits 7..4.
// - Both length registers are zero after reset and while enable is low.
// - Both length registers clear by themselves at the end of each frame.
// - Bit 0 of the second register flags a final byte shorter than 8 bits.
// - Bits 3..1 of the second register give the bits sent of that byte.
// - The partial bit count is used only when the flag is set.
// - FIFO status low nibble reads unread bytes minus one.
// - FIFO status flags overflow when more bytes are written than fit.
module txlen_regs
    import txlen_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // Chip enable
    input  wire logic       chipEnable,
    // Register port
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [4:0] regAddr,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    // FIFO write from host
    input  wire logic       fifoWrite,
    input  wire logic [7:0] fifoWrData,
    // Transmit control
    input  wire logic       txStart,
    input  wire logic       bitReady,
    output logic            txBit,
    output logic            txBitValid,
    output logic            txActive,
    output logic            txEof,
    output logic      [7:0] txLengthHigh,
    output logic      [7:0] txLengthLow
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]   lenHigh, next_lenHigh;
    logic [7:0]   lenLow, next_lenLow;
    logic [3:0]   wrPtr, next_wrPtr;
    logic [3:0]   rdPtr, next_rdPtr;
    logic [3:0]   fifoCount, next_fifoCount;
    logic         overflow, next_overflow;
    txlen_state_t state, next_state;
    logic [11:0]  bytesLeft, next_bytesLeft;
    logic [2:0]   bitIdx, next_bitIdx;
    logic [2:0]   bitLimit, next_bitLimit;
    logic [7:0]   shiftReg, next_shiftReg;
    logic         loadPend, next_loadPend;
    logic [7:0]   rdData, next_rdOut;
    logic         eofPulse;
    logic         fifoPop;
    logic         doPush;
    logic [7:0]   rdOut;

    // ------------------------------------------------------------------
    // FIFO storage
    // ------------------------------------------------------------------
    // A full FIFO still takes a byte in the cycle that frees a slot
    assign doPush = fifoWrite && (fifoCount != TXLEN_CNT_FULL || fifoPop);

    txlen_fifo_mem u_mem (
        .core_clk (core_clk),
        .wrEn     (doPush),
        .wrAddr   (wrPtr),
        .wrData   (fifoWrData),
        .rdAddr   (rdPtr),
        .rdData   (rdData)
    );

    // ------------------------------------------------------------------
    // Length registers and FIFO pointers
    // ------------------------------------------------------------------
    // Next values of registers, pointers and flags
    always_comb begin
        next_lenHigh   = lenHigh;
        next_lenLow    = lenLow;
        next_wrPtr     = wrPtr;
        next_rdPtr     = rdPtr;
        next_fifoCount = fifoCount;
        next_overflow  = overflow;
        if (regWrite && regAddr == TXLEN_ADDR_HIGH) begin
            next_lenHigh = regWrData;
        end
        if (regWrite && regAddr == TXLEN_ADDR_LOW) begin
            next_lenLow = regWrData;
        end
        if (doPush) begin
            next_wrPtr = (wrPtr == 4'(TXLEN_FIFO_DEPTH - 1)) ? 4'h0
                                                             : wrPtr + 4'h1;
        end
        if (fifoPop) begin
            next_rdPtr = (rdPtr == 4'(TXLEN_FIFO_DEPTH - 1)) ? 4'h0
                                                             : rdPtr + 4'h1;
        end
        next_fifoCount = fifoCount + {3'h0, doPush} - {3'h0, fifoPop};
        if (eofPulse) begin
            next_lenHigh  = TXLEN_RESET_VALUE;
            next_lenLow   = TXLEN_RESET_VALUE;
            next_overflow = 1'b0;
        end
        // Overflow set wins over the frame-end clear
        if (fifoWrite && !doPush) begin
            next_overflow = 1'b1;
        end
        if (!chipEnable) begin
            next_lenHigh   = TXLEN_RESET_VALUE;
            next_lenLow    = TXLEN_RESET_VALUE;
            next_wrPtr     = 4'h0;
            next_rdPtr     = 4'h0;
            next_fifoCount = TXLEN_CNT_ZERO;
            next_overflow  = 1'b0;
        end
    end

    // Register the length and FIFO state
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lenHigh   <= TXLEN_RESET_VALUE;
            lenLow    <= TXLEN_RESET_VALUE;
            wrPtr     <= 4'h0;
            rdPtr     <= 4'h0;
            fifoCount <= TXLEN_CNT_ZERO;
            overflow  <= 1'b0;
        end else begin
            lenHigh   <= next_lenHigh;
            lenLow    <= next_lenLow;
            wrPtr     <= next_wrPtr;
            rdPtr     <= next_rdPtr;
            fifoCount <= next_fifoCount;
            overflow  <= next_overflow;
        end
    end

    // ------------------------------------------------------------------
    // Transmit encoder
    // ------------------------------------------------------------------
    // Next encoder state; pops a byte, shifts it out MSB first
    always_comb begin
        next_state     = state;
        next_bytesLeft = bytesLeft;
        next_bitIdx    = bitIdx;
        next_bitLimit  = bitLimit;
        next_shiftReg  = shiftReg;
        next_loadPend  = 1'b0;
        fifoPop        = 1'b0;
        eofPulse       = 1'b0;
        unique case (state)
            TXLEN_IDLE: begin
                if (txStart) begin
                    next_bytesLeft = {lenHigh,
                        lenLow[TXLEN_LOW_NIB_MSB:TXLEN_LOW_NIB_LSB]};
                    // Partial count honoured only with flag set
                    next_bitLimit = lenLow[TXLEN_PART_FLAG]
                        ? lenLow[TXLEN_PART_MSB:TXLEN_PART_LSB]
                        : 3'h0;
                    if (next_bytesLeft != 12'h000) begin
                        next_state = TXLEN_BYTES;
                        fifoPop    = fifoCount != TXLEN_CNT_ZERO;
                        next_loadPend = fifoPop;
                    end else if (next_bitLimit != 3'h0) begin
                        next_state = TXLEN_PART;
                        fifoPop    = fifoCount != TXLEN_CNT_ZERO;
                        next_loadPend = fifoPop;
                    end else begin
                        next_state = TXLEN_EOF;
                    end
                    next_bitIdx = 3'h0;
                end
            end
            TXLEN_BYTES, TXLEN_PART: begin
                if (loadPend) begin
                    next_shiftReg = rdData;
                end else if (txBitValid && bitReady) begin
                    next_shiftReg = {shiftReg[6:0], 1'b0};
                    next_bitIdx   = bitIdx + 3'h1;
                    if (state == TXLEN_BYTES && bitIdx == 3'h7) begin
                        next_bytesLeft = bytesLeft - 12'h001;
                        if (bytesLeft != 12'h001 || bitLimit != 3'h0) begin
                            fifoPop = fifoCount != TXLEN_CNT_ZERO;
                            next_loadPend = fifoPop;
                            next_state = (bytesLeft != 12'h001)
                                ? TXLEN_BYTES : TXLEN_PART;
                        end else begin
                            next_state = TXLEN_EOF;
                        end
                    end else if (state == TXLEN_PART &&
                                 next_bitIdx == bitLimit) begin
                        next_state = TXLEN_EOF;
                    end
                end
            end
            TXLEN_EOF: begin
                eofPulse   = 1'b1;
                next_state = TXLEN_IDLE;
            end
        endcase
        if (!chipEnable) begin
            next_state = TXLEN_IDLE;
        end
    end

    // Register encoder state
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state     <= TXLEN_IDLE;
            bytesLeft <= 12'h000;
            bitIdx    <= 3'h0;
            bitLimit  <= 3'h0;
            shiftReg  <= 8'h00;
            loadPend  <= 1'b0;
        end else begin
            state     <= next_state;
            bytesLeft <= next_bytesLeft;
            bitIdx    <= next_bitIdx;
            bitLimit  <= next_bitLimit;
            shiftReg  <= next_shiftReg;
            loadPend  <= next_loadPend;
        end
    end

    // ------------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------------
    // Read mux; status shows count minus one and overflow
    always_comb begin
        next_rdOut = regRdData;
        if (regRead) begin
            unique case (regAddr)
                TXLEN_ADDR_HIGH: next_rdOut = lenHigh;
                TXLEN_ADDR_LOW:  next_rdOut = lenLow;
                TXLEN_ADDR_FIFO: next_rdOut = {3'h0, overflow,
                    fifoCount - 4'h1};
                default:         next_rdOut = 8'h00;
            endcase
        end
    end

    // Registered read data and end-of-frame pulse
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdOut <= 8'h00;
            txEof <= 1'b0;
        end else begin
            rdOut <= next_rdOut;
            txEof <= eofPulse;
        end
    end

    assign regRdData    = rdOut;
    assign txBit        = shiftReg[7];
    assign txBitValid   = (state == TXLEN_BYTES || state == TXLEN_PART) &&
                          !loadPend;
    assign txActive     = state != TXLEN_IDLE;
    assign txLengthHigh = lenHigh;
    assign txLengthLow  = lenLow;

endmodule // txlen_regs

// File: test/txlen_regs_sva.sv
`timescale 1ns/1ps
// ---------------------------------
// Length register checker
// ---------------------------------
module txlen_regs_sva
    import txlen_pkg::*;
(
    // Clock, reset, enable
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic       chipEnable,
    // Register port
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    // Transmit side
    input wire logic       txStart,
    input wire logic       bitReady,
    input wire logic       txBitValid,
    input wire logic       txActive,
    input wire logic       txEof,
    input wire logic [7:0] txLengthHigh,
    input wire logic [7:0] txLengthLow
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic [15:0] bitCnt;
    logic [15:0] next_bitCnt;
    logic [15:0] expBits;
    logic [15:0] next_expBits;
    // Bits accepted per frame against the programmed length
    always_comb begin
        next_bitCnt = bitCnt;
        next_expBits = expBits;
        if (txStart && !txActive) begin
            next_bitCnt = 16'h0000;
            next_expBits = {1'b0, txLengthHigh, txLengthLow[7:4], 3'b000}
                + (txLengthLow[0] ? {13'h0000, txLengthLow[3:1]} : 16'h0000);
        end else if (txBitValid && bitReady) begin
            next_bitCnt = bitCnt + 16'h0001;
        end
    end
    // Register the counters
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bitCnt <= 16'h0000;
            expBits <= 16'h0000;
        end else begin
            bitCnt <= next_bitCnt;
            expBits <= next_expBits;
        end
    end
    AST_CE_CLR: assert property (!chipEnable |=>
        txLengthHigh == 8'h00 && txLengthLow == 8'h00) else $error("enable");
    AST_EOF_CLR: assert property (txEof |->
        txLengthHigh == 8'h00 && txLengthLow == 8'h00) else $error("eof");
    AST_WR_HI: assert property (regWrite && chipEnable &&
        regAddr == TXLEN_ADDR_HIGH |=> txEof || txLengthHigh == $past(regWrData))
        else $error("high write");
    AST_WR_LO: assert property (regWrite && chipEnable &&
        regAddr == TXLEN_ADDR_LOW |=> txEof || txLengthLow == $past(regWrData))
        else $error("low write");
    AST_HOLD: assert property (chipEnable && !regWrite |=> txEof ||
        ($stable(txLengthHigh) && $stable(txLengthLow))) else $error("hold");
    AST_RD: assert property (regRead && regAddr == TXLEN_ADDR_LOW |=>
        regRdData == $past(txLengthLow)) else $error("read");
    AST_RD_HOLD: assert property (!regRead |=> $stable(regRdData))
        else $error("read hold");
    AST_EOF_ONE: assert property (txEof |=> !txEof) else $error("pulse");
    AST_START: assert property (txStart && !txActive && chipEnable
        |=> txActive) else $error("start");
    AST_BITS: assert property (txEof |-> bitCnt == expBits)
        else $error("bit count");
endmodule // txlen_regs_sva
bind txlen_regs txlen_regs_sva txlen_regs_sva_inst (.core_clk(core_clk),
    .resetn(resetn), .chipEnable(chipEnable), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .txStart(txStart), .bitReady(bitReady),
    .txBitValid(txBitValid), .txActive(txActive), .txEof(txEof),
    .txLengthHigh(txLengthHigh), .txLengthLow(txLengthLow));

// File: test/txlen_sink.sv
`timescale 1ns/1ps
// ---------------------------------
// Bit consumer at the encoder side
// ---------------------------------
module txlen_sink (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // Pace select
    input  wire logic slowMode,
    // Encoder side
    input  wire logic txBit,
    input  wire logic txBitValid,
    output logic      bitReady,
    // Observed bits
    output logic      rxBit,
    output logic      rxStrobe
);
    logic [7:0] lfsr;
    // Ready pattern and capture of accepted bits
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lfsr <= 8'h5A;
            bitReady <= 1'b0;
            rxStrobe <= 1'b0;
            rxBit <= 1'b0;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            bitReady <= slowMode ? lfsr[0] : 1'b1;
            rxStrobe <= txBitValid && bitReady;
            rxBit <= txBit;
        end
    end
endmodule // txlen_sink

// File: test/txlen_tb.sv
`timescale 1ns/1ps
// ---------------------------------
// Testbench
// ---------------------------------
module tb;
    import txlen_pkg::*;
    logic       core_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       chipEnable = 1'b0;
    logic       regWrite = 1'b0;
    logic       regRead = 1'b0;
    logic       fifoWrite = 1'b0;
    logic       txStart = 1'b0;
    logic       slowMode = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] fifoWrData = 8'h00;
    logic [7:0] regRdData, txLengthHigh, txLengthLow;
    logic       bitReady, txBit, txBitValid, txActive, txEof, rxBit, rxStrobe;
    logic       rdSeen = 1'b0;
    logic [31:0] seed = 32'h20380474;
    logic [7:0] rdQ[$];
    logic       bitQ[$];
    int         err_total = 0;
    int         check_count = 0;
    always #12.5 core_clk = ~core_clk;
    txlen_regs txlen_regs_inst (.core_clk(core_clk), .resetn(resetn),
        .chipEnable(chipEnable), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .fifoWrite(fifoWrite), .fifoWrData(fifoWrData), .txStart(txStart),
        .bitReady(bitReady), .txBit(txBit), .txBitValid(txBitValid),
        .txActive(txActive), .txEof(txEof), .txLengthHigh(txLengthHigh),
        .txLengthLow(txLengthLow));
    txlen_sink txlen_sink_inst (.core_clk(core_clk), .resetn(resetn),
        .slowMode(slowMode), .txBit(txBit), .txBitValid(txBitValid),
        .bitReady(bitReady), .rxBit(rxBit), .rxStrobe(rxStrobe));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // One pulse: 0 write, 1 read, 2 FIFO push, 3 start
    task automatic pulse(input int k, input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        fifoWrData <= d;
        case (k)
            0: regWrite <= 1'b1;
            1: regRead <= 1'b1;
            2: fifoWrite <= 1'b1;
            default: txStart <= 1'b1;
        endcase
        @(posedge core_clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        fifoWrite <= 1'b0;
        txStart <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        rdQ.push_back(e);
        pulse(1, a, 8'h00);
    endtask
    // Clear by enable, load FIFO and lengths, send, then expect cleared
    task automatic frame(input logic [11:0] cnt, input logic flag,
                         input logic [2:0] bb, input logic slow);
        logic [7:0] b;
        int i;
        @(posedge core_clk);
        chipEnable <= 1'b0;
        slowMode <= slow;
        repeat (2) @(posedge core_clk);
        chipEnable <= 1'b1;
        rd(TXLEN_ADDR_HIGH, 8'h00);
        for (i = 0; i < cnt + flag; i++) begin
            seed = xs(seed);
            b = seed[7:0];
            pulse(2, 5'h00, b);
            for (int j = 7; j >= 0; j--)
                if (i < cnt || 7 - j < bb) bitQ.push_back(b[j]);
        end
        if (cnt == 12'd12) begin
            rd(TXLEN_ADDR_FIFO, 8'h0B);
            pulse(2, 5'h00, 8'hA5);
            rd(TXLEN_ADDR_FIFO, 8'h1B);
        end
        pulse(0, TXLEN_ADDR_HIGH, cnt[11:4]);
        pulse(0, TXLEN_ADDR_LOW, {cnt[3:0], bb, flag});
        pulse(3, 5'h00, 8'h00);
        for (i = 0; i < 4000 && txEof !== 1'b1; i++) @(posedge core_clk);
        check({7'h00, txEof}, 8'h01);
        rd(TXLEN_ADDR_HIGH, 8'h00);
        rd(TXLEN_ADDR_LOW, 8'h00);
        if (cnt == 12'd12) rd(TXLEN_ADDR_FIFO, 8'h0F);
        check(8'(bitQ.size()), 8'h00);
    endtask
    // Result watcher: read data one cycle after the read, and sent bits
    always @(posedge core_clk) begin
        if (rdSeen) check(regRdData, rdQ.pop_front());
        if (rxStrobe) check({7'h00, rxBit}, {7'h00, bitQ.pop_front()});
        rdSeen = regRead;
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        chipEnable <= 1'b1;
        rd(TXLEN_ADDR_HIGH, 8'h00);
        rd(TXLEN_ADDR_FIFO, 8'h0F);
        rd(5'h05, 8'h00);
        repeat (4) begin
            seed = xs(seed);
            pulse(0, TXLEN_ADDR_HIGH, seed[7:0]);
            pulse(0, TXLEN_ADDR_LOW, seed[15:8]);
            rd(TXLEN_ADDR_HIGH, seed[7:0]);
            rd(TXLEN_ADDR_LOW, seed[15:8]);
        end
        // Let the last read be compared before reset clears it
        repeat (2) @(posedge core_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        rd(TXLEN_ADDR_LOW, 8'h00);
        frame(12'd12, 1'b0, 3'd0, 1'b1);
        frame(12'd1, 1'b1, 3'd3, 1'b0);
        frame(12'd0, 1'b1, 3'd5, 1'b1);
        frame(12'd3, 1'b0, 3'd7, 1'b0);
        frame(12'd0, 1'b0, 3'd0, 1'b1);
        frame(12'd2, 1'b1, 3'd7, 1'b1);
        repeat (4) @(posedge core_clk);
        summarize;
    end
    // Watchdog
    initial begin
        #400000;
        err_total++;
        summarize;
    end
endmodule // tb
